// ==== hdl/gsp_map.svh ====
/*
 * Constants of the three-channel gamma PWM core: latch field positions,
 * write key, gamma breakpoints, period end and timing rates.
 * Assumes it is included by bare name from the design files only.
 */
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH

// Latch field positions inside the 32-bit shift word
`define GSP_CH2_LSB        0
`define GSP_CH1_LSB        8
`define GSP_CH0_LSB        16
`define GSP_KEY_LSB        24
`define GSP_FIELD_W        8

// Write key that gates a latch transfer
`define GSP_WRITE_KEY      8'h3A

// Reset value of the grayscale latch
`define GSP_LATCH_RST      24'h000000

// Gamma curve: slope 2 below 8, slope 4 below 32, slope 8 above
`define GSP_KNEE_LOW       8'h08
`define GSP_KNEE_HIGH      8'h20
`define GSP_OFS_MID        12'h00E
`define GSP_OFS_TOP        12'h08A

// Counter values: start of period and longest turn-off point
`define GSP_CNT_ZERO       11'h000
`define GSP_CNT_FIRST      11'h001
`define GSP_CNT_LAST       11'h76E

// Timing rates in kHz: system clock and grayscale reference
`define GSP_SYS_CLK_KHZ    14'h2710
`define GSP_GRAY_CLK_KHZ   14'h1770
`define GSP_ACC_ZERO       14'h0000

`endif

// ==== hdl/gsp_pkg.sv ====
/*
 * Types of the three-channel gamma PWM core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gsp_pkg;

   typedef logic [10:0] gsp_count_type;
   typedef logic [7:0]  gsp_gray_type;

   // One-hot sequencer states
   typedef enum logic [1:0] {
      GSP_ST_HOLD = 2'b01,
      GSP_ST_RUN  = 2'b10
   } gsp_state_type;

endpackage : gsp_pkg

// ==== hdl/gsp_cmp_if.sv ====
/*
 * Carrier from the counter sequencer to the per-channel comparators.
 * Assumes one sequencer driving and any number of channels listening.
 */
`timescale 1ns/100ps

interface gsp_cmp_if;
   gsp_pkg::gsp_count_type count;
   logic                   run;
   logic                   clear;

   modport seq  (output count, output run, output clear);
   modport chan (input count, input run, input clear);
endinterface : gsp_cmp_if

// ==== hdl/gsp_channel.sv ====
/*
 * One PWM channel: gamma turn-off point and registered output level.
 * Assumes the sequencer drives count, run and clear on the same clock.
 */
`timescale 1ns/100ps
`include "gsp_map.svh"

module gsp_channel (
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   input  wire logic          clk_en,
   gsp_cmp_if.chan            cmp,
   input  wire logic [7:0]    gray_value,
   output logic               level
);

   logic [11:0] value_w;
   logic [11:0] off_point;
   logic [11:0] count_w;
   logic        in_window;
   logic        level_d;
   logic        level_q;

   assign value_w = {4'h0, gray_value};

   // Piecewise gamma: turn-off count grows faster at higher codes
   assign off_point = (gray_value < `GSP_KNEE_LOW)  ? {value_w[10:0], 1'b0} :
                      (gray_value < `GSP_KNEE_HIGH) ? {value_w[9:0], 2'b00} - `GSP_OFS_MID :
                                                      {value_w[8:0], 3'b000} - `GSP_OFS_TOP;

   assign count_w   = {1'b0, cmp.count};

   // On from count 1 while the count is below the turn-off point
   assign in_window = (cmp.count >= `GSP_CNT_FIRST) && (count_w < off_point);

   // Zero code never lights; a latch update forces off
   assign level_d   = cmp.run && !cmp.clear && (gray_value != 8'h00) && in_window;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         level_q <= 1'b0;
      end else if (clk_en) begin
         level_q <= level_d;
      end
   end

   assign level = level_q;

   default clocking ch_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   AST_GAMMA_LOW: assert property (gray_value == 8'h02 |-> off_point == 12'h004)
      else $error("gamma point for code 2 wrong");
   AST_GAMMA_MID: assert property (gray_value == 8'h20 |-> off_point == 12'h076)
      else $error("gamma point for code 32 wrong");
   AST_GAMMA_TOP: assert property (gray_value == 8'hFF |-> off_point == 12'h76E)
      else $error("gamma point for code 255 wrong");
   AST_ON_AT_ONE: assert property (
      clk_en && cmp.run && !cmp.clear && cmp.count == `GSP_CNT_FIRST && gray_value != 8'h00
      |=> level)
      else $error("channel not on at count 1");
   AST_ZERO_DARK: assert property (clk_en && gray_value == 8'h00 |=> !level)
      else $error("zero code channel lit");
   AST_OFF_PAST_POINT: assert property (clk_en && count_w >= off_point |=> !level)
      else $error("channel on past its turn-off point");

endmodule : gsp_channel

// ==== hdl/gsp_core.sv ====
/*
 * Three-channel grayscale PWM core with gamma correction.
 * Assumes the serial front end presents the assembled 32-bit shift word
 * and a one-cycle latch transfer pulse, both synchronous to clk_sys.
 */
`timescale 1ns/100ps
`include "gsp_map.svh"

module gsp_core (
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   input  wire logic          clk_en,
   input  wire logic [31:0]   shift_word,
   input  wire logic          latch_transfer_pulse,
   output logic               channel0_level,
   output logic               channel1_level,
   output logic               channel2_level
);

   gsp_cmp_if cmp ();

   logic [23:0]              gray_latch_q;
   logic [23:0]              gray_latch_d;
   logic [13:0]              phase_acc_q;
   logic [13:0]              phase_acc_d;
   logic [13:0]              phase_sum;
   gsp_pkg::gsp_count_type   count_q;
   gsp_pkg::gsp_count_type   count_d;
   gsp_pkg::gsp_state_type   state_q;
   gsp_pkg::gsp_state_type   state_d;
   logic [7:0]               latch_write_key;
   logic                     gray_tick_clock;
   logic                     latch_load;
   logic                     period_end;

   assign latch_write_key = shift_word[`GSP_KEY_LSB +: `GSP_FIELD_W];

   // Only a keyed transfer replaces the latch
   assign latch_load   = latch_transfer_pulse && (latch_write_key == `GSP_WRITE_KEY);
   assign gray_latch_d = latch_load ? shift_word[23:0] : gray_latch_q;

   // Fractional divider: 6 ticks per 10 system clocks gives the 6 MHz reference
   assign phase_sum       = phase_acc_q + `GSP_GRAY_CLK_KHZ;
   assign gray_tick_clock = (phase_sum >= `GSP_SYS_CLK_KHZ);
   assign phase_acc_d     = gray_tick_clock ? phase_sum - `GSP_SYS_CLK_KHZ : phase_sum;

   assign period_end = (count_q == `GSP_CNT_LAST);

   // Sequencer: hold at zero after a load, run until the next load
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      case (state_q)
         gsp_pkg::GSP_ST_HOLD: begin
            if (gray_tick_clock) begin
               state_d = gsp_pkg::GSP_ST_RUN;
               count_d = `GSP_CNT_FIRST;
            end
         end
         gsp_pkg::GSP_ST_RUN: begin
            if (gray_tick_clock) begin
               // Wrap back to count 1 so every period starts with a turn-on
               count_d = period_end ? `GSP_CNT_FIRST : count_q + `GSP_CNT_FIRST;
            end
         end
         default: begin
            state_d = gsp_pkg::GSP_ST_HOLD;
            count_d = `GSP_CNT_ZERO;
         end
      endcase
      if (latch_load) begin
         state_d = gsp_pkg::GSP_ST_HOLD;
         count_d = `GSP_CNT_ZERO;
      end
   end

   // Latch powers up empty, so all channels stay dark
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gray_latch_q <= `GSP_LATCH_RST;
         phase_acc_q  <= `GSP_ACC_ZERO;
         count_q      <= `GSP_CNT_ZERO;
         state_q      <= gsp_pkg::GSP_ST_HOLD;
      end else if (clk_en) begin
         gray_latch_q <= gray_latch_d;
         phase_acc_q  <= phase_acc_d;
         count_q      <= count_d;
         state_q      <= state_d;
      end
   end

   assign cmp.count = count_q;
   assign cmp.run   = (state_q == gsp_pkg::GSP_ST_RUN);
   assign cmp.clear = latch_load;

   // One comparator per channel, each on its own latch field
   gsp_channel u_ch0 (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .cmp        (cmp.chan),
      .gray_value (gray_latch_q[`GSP_CH0_LSB +: `GSP_FIELD_W]),
      .level      (channel0_level)
   );

   gsp_channel u_ch1 (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .cmp        (cmp.chan),
      .gray_value (gray_latch_q[`GSP_CH1_LSB +: `GSP_FIELD_W]),
      .level      (channel1_level)
   );

   gsp_channel u_ch2 (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .clk_en     (clk_en),
      .cmp        (cmp.chan),
      .gray_value (gray_latch_q[`GSP_CH2_LSB +: `GSP_FIELD_W]),
      .level      (channel2_level)
   );

   default clocking core_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // Never two idle enabled cycles in a row at a 6/10 tick ratio
   AST_TICK_RATE: assert property (
      clk_en && !gray_tick_clock ##1 clk_en |-> gray_tick_clock)
      else $error("grayscale tick rate too slow");
   AST_CNT_STEP: assert property (
      clk_en && gray_tick_clock && cmp.run && !period_end && !latch_load
      |=> count_q == $past(count_q) + 11'h001)
      else $error("counter did not advance on tick");
   AST_LOAD_CLEAR: assert property (
      clk_en && latch_load
      |=> count_q == 11'h000 && !channel0_level && !channel1_level && !channel2_level)
      else $error("latch update did not clear counter and outputs");
   AST_HOLD_UNTIL_TICK: assert property (
      clk_en && latch_load ##1 !gray_tick_clock |=> count_q == 11'h000)
      else $error("counter moved before next tick");
   AST_EMPTY_DARK: assert property (
      gray_latch_q == 24'h000000 |-> !channel0_level && !channel1_level && !channel2_level)
      else $error("output lit with empty latch");
   AST_FIELD_MAP: assert property (
      clk_en && latch_load
      |=> gray_latch_q[7:0] == $past(shift_word[7:0])
          && gray_latch_q[23:16] == $past(shift_word[23:16]))
      else $error("latch fields misplaced");
   AST_KEY_GATE: assert property (
      latch_transfer_pulse && latch_write_key != 8'h3A |=> $stable(gray_latch_q))
      else $error("latch changed without write key");
   AST_WRAP: assert property (
      clk_en && gray_tick_clock && cmp.run && period_end && !latch_load
      |=> count_q == 11'h001)
      else $error("period did not wrap to count 1");


   // Counter stays inside one period while running
   AST_RUN_RANGE: assert property (
      cmp.run |-> count_q != `GSP_CNT_ZERO && count_q <= `GSP_CNT_LAST)
      else $error("counter out of range while running");

   // Three ticks in a row would push the rate above 6 of 10 cycles
   AST_TICK_SPACING: assert property (
      clk_en && gray_tick_clock ##1 clk_en && gray_tick_clock ##1 clk_en
      |-> !gray_tick_clock)
      else $error("grayscale tick rate too fast");
   AST_TICK_ONLY: assert property (
      clk_en && !gray_tick_clock && !latch_load |=> $stable(count_q))
      else $error("counter moved without a tick");

   // After a load the first tick starts the period at count 1
   AST_FIRST_TICK: assert property (
      clk_en && gray_tick_clock && !cmp.run && !latch_load
      |=> cmp.run && count_q == 11'h001)
      else $error("counting did not resume on first tick");
   AST_HOLD_STILL: assert property (
      clk_en && !cmp.run && !gray_tick_clock && !latch_load |=> count_q == 11'h000)
      else $error("counter moved while holding");
   AST_HOLD_DARK: assert property (
      clk_en && !cmp.run |=> !channel0_level && !channel1_level && !channel2_level)
      else $error("output lit while sequencer holds");
   AST_LOAD_HOLD: assert property (
      clk_en && latch_load |=> !cmp.run)
      else $error("sequencer kept running after a load");

   // A zero code must never light channel 0, even across a reload
   AST_CH0_NONZERO: assert property (
      channel0_level |-> gray_latch_q[`GSP_CH0_LSB +: `GSP_FIELD_W] != 8'h00)
      else $error("channel 0 lit with zero code");

   // Whole word lands in one step; channel 1 sits in the middle byte
   AST_MID_FIELD: assert property (
      clk_en && latch_load |=> gray_latch_q[15:8] == $past(shift_word[15:8]))
      else $error("channel 1 field misplaced");
   AST_KEYED_COPY: assert property (
      clk_en && latch_load |=> gray_latch_q == $past(shift_word[23:0]))
      else $error("keyed load did not copy the word");
   AST_NO_PULSE_HOLD: assert property (
      !latch_load |=> $stable(gray_latch_q))
      else $error("latch changed without a keyed transfer");

   // A frozen enable must not let the period drift or channels 0 and 2 move
   AST_FREEZE: assert property (
      !clk_en |=> $stable(count_q) && $stable(phase_acc_q) && $stable(gray_latch_q)
                  && $stable(state_q) && $stable(channel0_level) && $stable(channel2_level))
      else $error("state moved while clock enable low");

   COV_LOAD: cover property (clk_en && latch_load);
   COV_WRAP: cover property (clk_en && gray_tick_clock && period_end);
   COV_ALL_ON: cover property (channel0_level && channel1_level && channel2_level);
   COV_REJECT: cover property (latch_transfer_pulse && !latch_load);
   COV_RELOAD_LIT: cover property (clk_en && latch_load && channel0_level);

endmodule : gsp_core

// ==== verif/gsp_led_sink.sv ====
/*
 * Behavioural LED string behind one current sink: reports each on-pulse.
 * Assumes level is registered on clk_sys; on-time counts enabled cycles.
 */
`timescale 1ns/100ps

module gsp_led_sink (
   input  wire logic        clk_sys,
   input  wire logic        clk_en,
   input  wire logic        level,
   output logic             done = 1'b0,
   output logic [15:0]      on_cycles = 16'h0000
);
   logic        lit_q = 1'b0;
   logic [15:0] cnt_q = 16'h0000;

   // Frozen cycles are not counted so that widths track the tick ratio
   always @(posedge clk_sys) begin
      done <= 1'b0;
      if (level === 1'b1) begin
         lit_q <= 1'b1;
         cnt_q <= cnt_q + {15'h0000, clk_en};
      end else if (lit_q) begin
         lit_q     <= 1'b0;
         done      <= 1'b1;
         on_cycles <= cnt_q;
         cnt_q     <= 16'h0000;
      end
   end
endmodule : gsp_led_sink

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench of the gamma PWM core with three LED sink models.
 * Assumes 10 MHz clk_sys and six grayscale ticks per ten enabled cycles.
 */
`timescale 1ns/100ps

module tb_top;
   logic        clk_sys              = 1'b0;
   logic        rst_b                = 1'b0;
   logic        clk_en               = 1'b1;
   logic [31:0] shift_word           = 32'h00000000;
   logic        latch_transfer_pulse = 1'b0;
   wire  [2:0]  lvl;
   wire  [2:0]  done;
   logic [15:0] w0, w1, w2;
   logic        hold_en              = 1'b1;
   logic [2:0]  zero_watch           = 3'b000;
   int          q [3][$];
   int          error_cnt            = 0;
   int          n_tests              = 0;
   logic [7:0]  tbl [8] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h20, 8'h40, 8'h80, 8'hFF};

   gsp_core gsp_core_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
      .shift_word(shift_word), .latch_transfer_pulse(latch_transfer_pulse),
      .channel0_level(lvl[0]), .channel1_level(lvl[1]), .channel2_level(lvl[2]));
   gsp_led_sink sink0_i (.clk_sys(clk_sys), .clk_en(clk_en), .level(lvl[0]),
      .done(done[0]), .on_cycles(w0));
   gsp_led_sink sink1_i (.clk_sys(clk_sys), .clk_en(clk_en), .level(lvl[1]),
      .done(done[1]), .on_cycles(w1));
   gsp_led_sink sink2_i (.clk_sys(clk_sys), .clk_en(clk_en), .level(lvl[2]),
      .done(done[2]), .on_cycles(w2));

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   always @(negedge clk_sys) begin
      clk_en <= hold_en ? 1'b1 : (($urandom % 8) != 0);
   end

   task automatic cmp(logic [31:0] e, logic [31:0] g, int tol);
      n_tests++;
      if ($isunknown(g) || g > e + tol || g + tol < e) begin
         error_cnt++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp

   task automatic chk_lvl(logic [2:0] e);
      n_tests++;
      if (lvl !== e) begin
         error_cnt++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, lvl);
      end
   endtask : chk_lvl

   // Width in enabled cycles of a pulse lit from tick 1 up to the off point
   function automatic int exp_w(int v);
      int off;
      off = (v < 8) ? 2 * v : (v < 32) ? 4 * v - 14 : 8 * v - 138;
      return ((off - 1) * 10 + 3) / 6;
   endfunction : exp_w

   // Pulses cut short by a reload are dropped: queues are flushed first
   always @(posedge clk_sys) begin
      for (int c = 0; c < 3; c++) begin
         logic [31:0] g;
         g = (c == 0) ? {16'h0000, w0} : (c == 1) ? {16'h0000, w1} : {16'h0000, w2};
         if (done[c] === 1'b1) begin
            if (q[c].size() > 0) cmp(q[c].pop_front(), g, 2);
            else if (zero_watch[c]) cmp(0, g, 0);
         end
      end
   end

   task automatic load(logic [7:0] k, logic [7:0] v0, v1, v2, int reps);
      logic [7:0] v [3];
      v = '{v0, v1, v2};
      hold_en = 1'b1;
      if (k == 8'h3A) begin
         zero_watch = 3'b000;
         for (int c = 0; c < 3; c++) q[c].delete();
      end
      @(negedge clk_sys);
      shift_word           <= {k, v0, v1, v2};
      latch_transfer_pulse <= 1'b1;
      @(negedge clk_sys);
      latch_transfer_pulse <= 1'b0;
      @(negedge clk_sys);
      if (k == 8'h3A) chk_lvl(3'b000);
      repeat (3) @(negedge clk_sys);
      hold_en = 1'b0;
      if (k == 8'h3A) begin
         for (int c = 0; c < 3; c++) begin
            if (v[c] == 8'h00) zero_watch[c] = 1'b1;
            else repeat (reps) q[c].push_back(exp_w(v[c]));
         end
      end
   endtask : load

   task automatic drain;
      int i;
      for (i = 0; i < 9000 && q[0].size() + q[1].size() + q[2].size() > 0; i++)
         @(negedge clk_sys);
      cmp(0, q[0].size() + q[1].size() + q[2].size(), 0);
   endtask : drain

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   initial begin
      void'($urandom(32'hD6396906));
      repeat (16) @(negedge clk_sys);
      rst_b      <= 1'b1;
      zero_watch = 3'b111;
      load(8'h3B, 8'hFF, 8'hFF, 8'hFF, 1);
      repeat (4000) @(negedge clk_sys);
      chk_lvl(3'b000);
      for (int i = 0; i < 8; i++) begin
         load(8'h3A, tbl[i], tbl[(i + 3) % 8], tbl[(i + 5) % 8], 1);
         drain();
      end
      load(8'h3A, 8'h00, 8'h05, 8'h00, 1);
      drain();
      repeat (6) begin
         load(8'h3A, 8'($urandom), 8'($urandom), 8'($urandom), 1);
         drain();
      end
      load(8'h3A, 8'hFF, 8'h00, 8'h00, 2);
      drain();
      load(8'h3A, 8'h60, 8'h60, 8'h60, 1);
      repeat (300) @(negedge clk_sys);
      load(8'h00, 8'hFF, 8'hFF, 8'hFF, 1);
      chk_lvl(3'b111);
      drain();
      load(8'h3A, 8'hFF, 8'hFF, 8'hFF, 1);
      repeat (500) @(negedge clk_sys);
      load(8'h3A, 8'h0A, 8'h14, 8'h1E, 1);
      drain();
      conclude();
   end

   // About 47k cycles expected; cut off at 90k
   initial begin
      #9000000;
      error_cnt++;
      conclude();
   end
endmodule : tb_top
